//--- ldc_pkg.sv
package ldc_pkg;

  // ==========================================================
  // channel and packet geometry
  localparam int NUM_CH = 16;
  localparam int GS_BITS = 12;
  localparam int TRIM_BITS = 6;
  localparam int GS_LEN = NUM_CH * GS_BITS;
  localparam int TRIM_LEN = NUM_CH * TRIM_BITS;

  // ==========================================================
  // pwm counter values
  localparam logic [GS_BITS-1:0] GS_ZERO = 12'h000;
  localparam logic [GS_BITS-1:0] GS_ONE = 12'h001;
  localparam logic [GS_BITS-1:0] GS_MAX = 12'hFFF;

  // ==========================================================
  // status readout word layout
  localparam int STAT_LOD_LSB = 0;
  localparam int STAT_THERM_BIT = 16;
  localparam int STAT_TRIM_LSB = 24;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int OPEN_DETECT_NS = 1000;
  // longest time, so the division rounds down
  localparam int OPEN_DETECT_CYC = OPEN_DETECT_NS / CLK_PERIOD_NS;
  localparam int DET_W = $clog2(OPEN_DETECT_CYC + 1);

  // ==========================================================
  // buffering
  localparam int BUF_DEPTH = 2;

  typedef enum logic [2:0] {
    PWM_IDLE = 3'h1,
    PWM_RUN = 3'h2,
    PWM_DONE = 3'h4
  } ldc_pwm_state_t;

  function automatic logic [GS_BITS-1:0] ldc_gray_of(input logic [GS_LEN-1:0] vec,
                                                     input int idx);
    return vec[idx*GS_BITS +: GS_BITS];
  endfunction : ldc_gray_of

endpackage : ldc_pkg

//--- ldc_buf_if.sv
`timescale 1ns/100ps
interface ldc_buf_if #(parameter int WIDTH = 1);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;

  modport store (input in_valid, input in_data, input out_ready,
                 output in_ready, output out_valid, output out_data);
  modport fill (output in_valid, output in_data, input in_ready);
  modport drain (input out_valid, input out_data, output out_ready);
endinterface : ldc_buf_if

//--- ldc_pair_buf.sv
`timescale 1ns/100ps
module ldc_pair_buf #(
  parameter int DEPTH = ldc_pkg::BUF_DEPTH
) (
  // clock and control
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // both sides of the buffer
  ldc_buf_if.store port
);
  import ldc_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == LAST) ? '0 : p + PW'(1);
  endfunction : ptr_inc

  logic [$bits(port.in_data)-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [CW-1:0] cnt_reg;
  logic push;
  logic pop;

  assign port.in_ready = (cnt_reg != FULL);
  assign port.out_valid = (cnt_reg != '0);
  assign port.out_data = mem_reg[rd_reg];
  assign push = port.in_valid & port.in_ready;
  assign pop = port.out_valid & port.out_ready;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_reg <= '0;
    end else if (clk_en) begin
      cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else if (clk_en) begin
      if (push) begin
        wr_reg <= ptr_inc(wr_reg);
      end
      if (pop) begin
        rd_reg <= ptr_inc(rd_reg);
      end
    end
  end

  // storage needs no reset: nothing reads an entry before it is written
  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem_reg[wr_reg] <= port.in_data;
    end
  end

endmodule : ldc_pair_buf

//--- ldc_core.sv
`timescale 1ns/100ps
module ldc_core #(
  parameter int DETECT_CYCLES = ldc_pkg::OPEN_DETECT_CYC
) (
  // clock and control
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // serial link, asynchronous pins
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic latch_strobe,
  input wire logic mode,
  output logic serial_out,
  output logic shift_ready,
  // pwm timing, asynchronous pins
  input wire logic pwm_count_clock,
  input wire logic blank,
  // analog sense, asynchronous
  input wire logic [ldc_pkg::NUM_CH-1:0] sink_low,
  input wire logic thermal_hot,
  // channel drive and status
  output logic [ldc_pkg::NUM_CH-1:0] sink_channel,
  output logic [ldc_pkg::TRIM_LEN-1:0] current_trim,
  output logic [ldc_pkg::NUM_CH-1:0] open_led_flag,
  output logic thermal_flag,
  // open-drain error pin
  output logic error_out_n_o,
  output logic error_out_n_oe_n
);
  import ldc_pkg::*;

  localparam int SYNC_W = 7 + NUM_CH;
  localparam logic [DET_W-1:0] DET_DONE = DET_W'(DETECT_CYCLES);

  // ==========================================================
  // pin synchronisers
  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;
  logic sclk_s;
  logic sin_s;
  logic lat_s;
  logic mode_s;
  logic pclk_s;
  logic blank_s;
  logic hot_s;
  logic [NUM_CH-1:0] low_s;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (clk_en) begin
      meta_reg <= {sink_low, thermal_hot, blank, pwm_count_clock, mode, latch_strobe,
                   serial_in, shift_clock};
      sync_reg <= meta_reg;
    end
  end

  assign sclk_s = sync_reg[0];
  assign sin_s = sync_reg[1];
  assign lat_s = sync_reg[2];
  assign mode_s = sync_reg[3];
  assign pclk_s = sync_reg[4];
  assign blank_s = sync_reg[5];
  assign hot_s = sync_reg[6];
  assign low_s = sync_reg[7 +: NUM_CH];

  // ==========================================================
  // edge detection on the synchronised pins
  logic sclk_prev_reg;
  logic lat_prev_reg;
  logic pclk_prev_reg;
  logic sclk_rise;
  logic lat_fall;
  logic pclk_rise;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sclk_prev_reg <= 1'b0;
      lat_prev_reg <= 1'b0;
      pclk_prev_reg <= 1'b0;
    end else if (clk_en) begin
      sclk_prev_reg <= sclk_s;
      lat_prev_reg <= lat_s;
      pclk_prev_reg <= pclk_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_reg;
  assign lat_fall = ~lat_s & lat_prev_reg;
  assign pclk_rise = pclk_s & ~pclk_prev_reg;

  // ==========================================================
  // serial bit buffer
  // a bit caught while the register is busy loading status waits here
  ldc_buf_if #(.WIDTH(1)) bit_if ();
  logic stat_load;
  logic pop;

  assign stat_load = lat_fall & ~mode_s;
  assign bit_if.in_valid = sclk_rise;
  assign bit_if.in_data = sin_s;
  assign bit_if.out_ready = ~lat_s & ~stat_load;
  assign shift_ready = bit_if.in_ready;
  assign pop = bit_if.out_valid & bit_if.out_ready;

  ldc_pair_buf #(.DEPTH(BUF_DEPTH)) u_bit_buf (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .port(bit_if.store)
  );

  // ==========================================================
  // input shift register and status readout
  logic [GS_LEN-1:0] sr_reg;
  logic [GS_LEN-1:0] status_word;
  logic [TRIM_LEN-1:0] trim_reg;
  logic [GS_LEN-1:0] gray_reg;
  logic serial_out_reg;

  always_comb begin
    status_word = '0;
    status_word[STAT_LOD_LSB +: NUM_CH] = open_led_flag;
    status_word[STAT_THERM_BIT] = hot_s;
    status_word[STAT_TRIM_LSB +: TRIM_LEN] = trim_reg;
  end

  // open flags are caught as the strobe returns low
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sr_reg <= '0;
    end else if (clk_en) begin
      if (stat_load) begin
        sr_reg <= status_word;
      end else if (pop) begin
        sr_reg <= {sr_reg[GS_LEN-2:0], bit_if.out_data};
      end
    end
  end

  // the tap moves with mode so the chain length is 96 or 192 bits
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      serial_out_reg <= 1'b0;
    end else if (clk_en) begin
      serial_out_reg <= mode_s ? sr_reg[TRIM_LEN-1] : sr_reg[GS_LEN-1];
    end
  end

  assign serial_out = serial_out_reg;

  // ==========================================================
  // level-sensitive latches
  // are relied on: mode and shifting stay still while strobe is high
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trim_reg <= '0;
    end else if (clk_en && lat_s && mode_s) begin
      trim_reg <= sr_reg[TRIM_LEN-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gray_reg <= '0;
    end else if (clk_en && lat_s && !mode_s) begin
      gray_reg <= sr_reg;
    end
  end

  // each trim value sets its sink to value/63 of full scale in the analog stage
  assign current_trim = trim_reg;

  // ==========================================================
  // pwm counter and state
  ldc_pwm_state_t state_reg;
  logic [GS_BITS-1:0] cnt_reg;
  logic [GS_BITS-1:0] cnt_next;

  assign cnt_next = cnt_reg + GS_ONE;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= PWM_IDLE;
    end else if (clk_en) begin
      if (blank_s) begin
        state_reg <= PWM_IDLE;
      end else if (pclk_rise) begin
        unique case (state_reg)
          PWM_IDLE: begin
            state_reg <= PWM_RUN;
          end
          PWM_RUN: begin
            if (cnt_next == GS_MAX) begin
              state_reg <= PWM_DONE;
            end
          end
          PWM_DONE: begin
            state_reg <= PWM_DONE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_reg <= GS_ZERO;
    end else if (clk_en) begin
      if (blank_s) begin
        cnt_reg <= GS_ZERO;
      end else if (pclk_rise && state_reg != PWM_DONE) begin
        cnt_reg <= cnt_next;
      end
    end
  end

  // ==========================================================
  // per-channel drive and open detection
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [GS_BITS-1:0] gray_ch;
    logic on_reg;
    logic flag_reg;
    logic [DET_W-1:0] det_reg;

    assign gray_ch = ldc_gray_of(gray_reg, ch);

    // off at the edge where the old count equals gray or the next count is max: on for gray clocks, 4094 at most
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        on_reg <= 1'b0;
      end else if (clk_en) begin
        if (blank_s) begin
          on_reg <= 1'b0;
        end else if (pclk_rise) begin
          unique case (state_reg)
            PWM_IDLE: begin
              on_reg <= (gray_ch != GS_ZERO);
            end
            PWM_RUN: begin
              if (cnt_next == GS_MAX || gray_ch == cnt_reg) begin
                on_reg <= 1'b0;
              end
            end
            PWM_DONE: begin
              on_reg <= 1'b0;
            end
          endcase
        end
      end
    end

    // flag holds while the sink is off so a blanked strobe can still read it
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        det_reg <= '0;
        flag_reg <= 1'b0;
      end else if (clk_en && on_reg) begin
        if (!low_s[ch]) begin
          det_reg <= '0;
          flag_reg <= 1'b0;
        end else if (det_reg == DET_DONE) begin
          flag_reg <= 1'b1;
        end else begin
          det_reg <= det_reg + DET_W'(1);
        end
      end
    end

    assign sink_channel[ch] = on_reg;
    assign open_led_flag[ch] = flag_reg;
  end

  // ==========================================================
  // error pin
  // open flags are masked by blanking so software can tell them from thermal
  logic err_oe_n_reg;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      err_oe_n_reg <= 1'b1;
    end else if (clk_en) begin
      err_oe_n_reg <= ~(hot_s | ((|open_led_flag) & ~blank_s));
    end
  end

  assign error_out_n_o = 1'b0;
  assign error_out_n_oe_n = err_oe_n_reg;
  assign thermal_flag = hot_s;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst || !clk_en);

  sequence s_cycle_start;
    state_reg == PWM_IDLE && !blank_s && pclk_rise;
  endsequence

  sequence s_pop_low;
    pop && !stat_load && !mode_s ##1 !mode_s;
  endsequence

  chk_trim_follow: assert property (lat_s && mode_s |=>
      trim_reg == $past(sr_reg[TRIM_LEN-1:0]))
    else $error("trim latch did not follow shift register");

  chk_trim_hold: assert property (!(lat_s && mode_s) |=> $stable(trim_reg))
    else $error("trim latch changed while closed");

  chk_gray_latch: assert property (lat_s && !mode_s |=> gray_reg == $past(sr_reg))
    else $error("gray latch did not take shift register");

  chk_status_load: assert property (stat_load |=>
      sr_reg[STAT_TRIM_LSB +: TRIM_LEN] == $past(trim_reg)
      && sr_reg[STAT_THERM_BIT] == $past(hot_s)
      && sr_reg[STAT_LOD_LSB +: NUM_CH] == $past(open_led_flag))
    else $error("status word not loaded after gray latch");

  chk_shift_out: assert property (s_pop_low |=>
      serial_out == $past(sr_reg[GS_LEN-2], 2))
    else $error("serial out did not present next lower bit");

  chk_blank_clear: assert property (blank_s |=> cnt_reg == GS_ZERO
      && sink_channel == '0)
    else $error("blanking did not clear counter and channels");

  chk_first_on: assert property (s_cycle_start |=> cnt_reg == GS_ONE
      && sink_channel[0] == (ldc_gray_of($past(gray_reg), 0) != GS_ZERO))
    else $error("first pwm clock did not start the cycle");

  chk_gray_off: assert property (state_reg == PWM_RUN && !blank_s && pclk_rise
      && ldc_gray_of(gray_reg, 1) == cnt_reg |=> !sink_channel[1])
    else $error("channel not switched off at its gray count");

  chk_count_stop: assert property ($rose(state_reg == PWM_DONE) |->
      cnt_reg == GS_MAX && sink_channel == '0 ##1 (blank_s || cnt_reg == GS_MAX))
    else $error("counter did not stop at maximum");

  chk_thermal_err: assert property (hot_s |=> !error_out_n_oe_n)
    else $error("thermal flag did not pull error pin");

  // every channel at once: a flag may only rise behind an on, low sink
  chk_open_cause: assert property ((open_led_flag & ~$past(open_led_flag)
      & ~($past(sink_channel) & $past(low_s))) == '0)
    else $error("open flag without an on, low sink");

endmodule : ldc_core

//--- ldc_ctrl_model.sv
`timescale 1ns/100ps
module ldc_ctrl_model (
  // clock
  input wire logic sys_clk,
  // serial link towards the device
  output logic shift_clock,
  output logic serial_in,
  output logic latch_strobe,
  output logic mode,
  input wire logic serial_out
);
  // ==========================================================
  // link clock of 125 ns, held low between frames
  logic [191:0] cap;

  initial begin
    shift_clock = 1'b0;
    serial_in = 1'b0;
    latch_strobe = 1'b0;
    mode = 1'b0;
    cap = '0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // serial_out is sampled just before the rising edge that replaces it
  task automatic pulse(input logic b, output logic so);
    serial_in <= b;
    tick(12);
    so = serial_out;
    shift_clock <= 1'b1;
    tick(12);
    shift_clock <= 1'b0;
    tick(1);
  endtask : pulse

  task automatic send(input logic m, input logic [191:0] d, input int n, input logic extra);
    logic so;
    mode <= m;
    tick(4);
    for (int i = n - 1; i >= 0; i--) begin
      pulse(d[i], so);
      cap[i] = so;
    end
    tick(4);
    latch_strobe <= 1'b1;
    tick(4);
    latch_strobe <= 1'b0;
    tick(6);
    if (extra) begin
      pulse(1'b0, so);
    end
    // a stale level on the data pin would hide a late sample
    serial_in <= ~serial_in;
  endtask : send
endmodule : ldc_ctrl_model

//--- tb_led_pwm_dot_correction_driver.sv
`timescale 1ns/100ps
module tb_led_pwm_dot_correction_driver;
  import ldc_pkg::*;
  // ==========================================================
  // stimulus and observation
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic pwm_count_clock = 1'b0;
  logic blank = 1'b1;
  logic [NUM_CH-1:0] sink_low = '0;
  logic thermal_hot = 1'b0;
  logic shift_clock, serial_in, latch_strobe, mode, serial_out, shift_ready;
  logic [NUM_CH-1:0] sink_channel, open_led_flag;
  logic [TRIM_LEN-1:0] current_trim;
  logic thermal_flag, error_out_n_o, error_out_n_oe_n;
  logic [GS_LEN-1:0] g2, gv;
  logic [TRIM_LEN-1:0] tv;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;

  always #2.5 sys_clk = ~sys_clk;

  ldc_ctrl_model ctrl (.sys_clk(sys_clk), .shift_clock(shift_clock), .serial_in(serial_in),
    .latch_strobe(latch_strobe), .mode(mode), .serial_out(serial_out));

  // short open-detect count keeps the run brief
  ldc_core #(.DETECT_CYCLES(4)) DUT (.sys_clk(sys_clk), .srst(srst), .clk_en(1'b1),
    .shift_clock(shift_clock), .serial_in(serial_in), .latch_strobe(latch_strobe),
    .mode(mode), .serial_out(serial_out), .shift_ready(shift_ready),
    .pwm_count_clock(pwm_count_clock), .blank(blank), .sink_low(sink_low),
    .thermal_hot(thermal_hot), .sink_channel(sink_channel), .current_trim(current_trim),
    .open_led_flag(open_led_flag), .thermal_flag(thermal_flag),
    .error_out_n_o(error_out_n_o), .error_out_n_oe_n(error_out_n_oe_n));

  // ==========================================================
  // reporting
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [191:0] seen, input logic [191:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      n_fail++;
      test_done();
    end
  end

  // ==========================================================
  // expectations
  function automatic logic [NUM_CH-1:0] exp_sink(input logic [GS_LEN-1:0] g, input int c);
    logic [NUM_CH-1:0] s;
    int cc;
    int gn;
    cc = (c > 4095) ? 4095 : c;
    for (int n = 0; n < NUM_CH; n++) begin
      gn = int'(g[n*GS_BITS +: GS_BITS]);
      s[n] = (gn != 0) && (cc <= gn) && (cc < 4095);
    end
    return s;
  endfunction : exp_sink

  function automatic logic [191:0] exp_status(input logic [95:0] t, input logic th,
                                              input logic [15:0] fl);
    return {72'h0, t, 7'h0, th, fl};
  endfunction : exp_status

  function automatic logic [GS_LEN-1:0] rand_gray();
    logic [GS_LEN-1:0] v;
    for (int n = 0; n < NUM_CH; n++) begin
      v[n*GS_BITS +: GS_BITS] = 12'($urandom);
    end
    return v;
  endfunction : rand_gray

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task automatic run_pwm(input logic [GS_LEN-1:0] g, input int n);
    blank <= 1'b0;
    tick(4);
    for (int c = 1; c <= n; c++) begin
      pwm_count_clock <= 1'b1;
      tick(4);
      pwm_count_clock <= 1'b0;
      tick(4);
      check("sink_channel", 192'(sink_channel), 192'(exp_sink(g, c)));
    end
  endtask : run_pwm

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(73716));
    tick(2);
    srst <= 1'b0;
    tick(4);
    check("serial_out", 192'(serial_out), 192'h0);
    check("current_trim", 192'(current_trim), 192'h0);
    check("sink_channel", 192'(sink_channel), 192'h0);
    check("error_out_n_oe_n", 192'(error_out_n_oe_n), 192'h1);
    check("error_out_n_o", 192'(error_out_n_o), 192'h0);
    check("shift_ready", 192'(shift_ready), 192'h1);
    $display("test reset done");
    gv = rand_gray();
    ctrl.send(1'b0, gv, 192, 1'b0);
    tv = {$urandom, $urandom, $urandom};
    tv[5:0] = 6'h3F;
    tv[95:90] = 6'h00;
    blank <= 1'b0;
    ctrl.send(1'b1, {96'h0, tv}, 96, 1'b0);
    check("current_trim", 192'(current_trim), 192'(tv));
    blank <= 1'b1;
    g2 = rand_gray();
    g2[47:0] = {12'hFFE, 12'hFFF, 12'h001, 12'h000};
    ctrl.send(1'b0, g2, 192, 1'b1);
    tick(2);
    check("current_trim held", 192'(current_trim), 192'(tv));
    $display("test loads done");
    sink_low <= 16'h0004;
    run_pwm(g2, 4097);
    check("open_led_flag", 192'(open_led_flag), 192'h4);
    check("error_out_n_oe_n", 192'(error_out_n_oe_n), 192'h0);
    blank <= 1'b1;
    tick(5);
    check("sink_channel blank", 192'(sink_channel), 192'h0);
    check("error_out_n_oe_n blank", 192'(error_out_n_oe_n), 192'h1);
    run_pwm(g2, 3);
    blank <= 1'b1;
    $display("test pwm done");
    thermal_hot <= 1'b1;
    tick(6);
    check("thermal_flag", 192'(thermal_flag), 192'h1);
    check("error_out_n_oe_n hot", 192'(error_out_n_oe_n), 192'h0);
    gv = rand_gray();
    ctrl.send(1'b0, gv, 192, 1'b0);
    gv = rand_gray();
    ctrl.send(1'b0, gv, 192, 1'b0);
    check("status_readout_word", ctrl.cap, exp_status(tv, 1'b1, 16'h0004));
    $display("test status done");
    test_done();
  end
endmodule : tb_led_pwm_dot_correction_driver
